// [hdl/esfm_pkg.sv]
// Constants shared by the engine sensor fault monitor modules.
// Assumes a single 10 MHz system clock; sensor voltages come in millivolts.
package esfm_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ          = 10_000_000;

  // Fuel temperature range check, thresholds in millivolts
  localparam logic [12:0] FTS_LOW_MV      = 13'h0064;   // 0.1 V
  localparam logic [12:0] FTS_HIGH_MV     = 13'h11f8;   // 4.6 V
  localparam int unsigned FTS_DEBOUNCE_S  = 5;
  localparam int unsigned FTS_DEBOUNCE_CYC = FTS_DEBOUNCE_S * CLK_HZ;
  localparam int unsigned FTS_CNT_W       = 26;
  // Substitute fuel temperature, degrees Celsius, two's complement
  localparam logic [7:0]  FTS_SUBST_C     = 8'h32;      // 50 C

  // Wheel geometry
  localparam int unsigned CRANK_SLOTS     = 36;
  localparam int unsigned PUMP_TEETH      = 6;          // per engine rev
  localparam int unsigned PUMP_WEIGHT     = CRANK_SLOTS / PUMP_TEETH;

  // Engine speed measurement window: one sixth of a second
  localparam int unsigned SPEED_WIN_DEN   = 6;
  localparam int unsigned SPEED_WIN_CYC   = CLK_HZ / SPEED_WIN_DEN;
  localparam int unsigned SPEED_WIN_W     = 21;
  localparam int unsigned RPM_PER_SLOT    = 60 * SPEED_WIN_DEN / CRANK_SLOTS;
  localparam int unsigned RPM_W           = 14;
  localparam logic [13:0] MIN_MON_RPM     = 14'h0190;   // 400 rpm

  // Missing pulse monitors
  localparam int unsigned CHECK_REVS      = 10;
  localparam int unsigned PUMP_MIN_PULSES = 40;
  localparam int unsigned CRANK_MIN_PULSES = 20;
  localparam int unsigned MON_CNT_W       = 8;

endpackage : esfm_pkg

// [hdl/esfm_mon_if.sv]
// Connection between the top module and one missing pulse monitor.
// Assumes every signal is on the system clock domain.
`timescale 1ns/1ps
interface esfm_mon_if;
  logic enable;        // Monitoring allowed
  logic sensor_pulse;  // One-cycle pulse from the watched sensor
  logic ref_pulse;     // One-cycle pulse from the reference sensor
  logic fault;         // Latched fault of the watched sensor

  modport mon (input enable, input sensor_pulse, input ref_pulse,
               output fault);
  modport ctl (output enable, output sensor_pulse, output ref_pulse,
               input fault);
endinterface : esfm_mon_if

// [hdl/esfm_pulse_shaper.sv]
// Turns a squared sensor waveform into one-cycle rising edge pulses.
// Assumes the raw input is asynchronous to clk.
`timescale 1ns/1ps
module esfm_pulse_shaper
(
  input  wire logic clk,    // System clock
  input  wire logic reset,  // Synchronous reset, active high
  input  wire logic raw,    // Squared sensor waveform from the pin
  output logic      pulse   // One-cycle pulse per rising edge
);

  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
  } esfm_shaper_t;

  esfm_shaper_t s;
  esfm_shaper_t next_s;

  always_comb
  begin
    next_s    = s;
    next_s.s1 = raw;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Edge taken only from the settled stages
  assign pulse = s.s2 & ~s.s3;

endmodule : esfm_pulse_shaper

// [hdl/esfm_pulse_monitor.sv]
// Missing pulse monitor: counts watched pulses over revolutions of the
// reference sensor. Assumes one-cycle pulses on the system clock.
`timescale 1ns/1ps
module esfm_pulse_monitor
#(
  parameter int unsigned MIN_PULSES = 40,  // Pulses needed per check span
  parameter int unsigned REF_TEETH  = 36   // Reference pulses per rev
)
(
  input  wire logic  clk,    // System clock
  input  wire logic  reset,  // Synchronous reset, active high
  esfm_mon_if.mon    port    // Enable, pulses and fault flag
);

  localparam int unsigned W = esfm_pkg::MON_CNT_W;
  localparam logic [W-1:0] MIN_CNT  = W'(MIN_PULSES);
  localparam logic [W-1:0] TEETH_M1 = W'(REF_TEETH - 1);
  localparam logic [W-1:0] REVS_M1  = W'(esfm_pkg::CHECK_REVS - 1);

  typedef enum logic [1:0] {MON_IDLE, MON_WATCH, MON_FAULT} esfm_mon_st_t;

  typedef struct packed
  {
    esfm_mon_st_t st;
    logic [W-1:0] tooth;
    logic [W-1:0] revs;
    logic [W-1:0] seen;
  } esfm_mon_t;

  esfm_mon_t s;
  esfm_mon_t next_s;

  always_comb
  begin
    next_s = s;
    case (s.st)
      MON_IDLE:
      begin
        next_s.tooth = '0;
        next_s.revs  = '0;
        next_s.seen  = '0;
        if (port.enable)
        begin
          next_s.st = MON_WATCH;
        end
      end
      MON_WATCH:
      begin
        if (!port.enable)
        begin
          next_s.st = MON_IDLE;
        end
        else
        begin
          // Saturate so a fast sensor never wraps to a low count
          if (port.sensor_pulse && s.seen != '1)
          begin
            next_s.seen = s.seen + W'(1);
          end
          if (port.ref_pulse)
          begin
            if (s.tooth == TEETH_M1)
            begin
              next_s.tooth = '0;
              if (s.revs == REVS_M1)
              begin
                next_s.revs = '0;
                // Span end check, this cycle's pulse included
                if (next_s.seen < MIN_CNT)
                begin
                  next_s.st = MON_FAULT;
                end
                next_s.seen = '0;
              end
              else
              begin
                next_s.revs = s.revs + W'(1);
              end
            end
            else
            begin
              next_s.tooth = s.tooth + W'(1);
            end
          end
        end
      end
      MON_FAULT:
      begin
        // Latched until reset
        next_s.st = MON_FAULT;
      end
      default:
      begin
        next_s.st = MON_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s <= '{st: MON_IDLE, default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign port.fault = (s.st == MON_FAULT);

endmodule : esfm_pulse_monitor

// [hdl/esfm_top.sv]
// Engine sensor fault monitor: fuel temperature range check with
// substitution, pump speed and crank position missing pulse checks with
// mutual takeover, and engine speed from the crank (or pump) pulses.
// Assumes squared sensor waveforms and ignition levels arrive on pins,
// and the fuel temperature voltage and reading come from ADC logic on clk.
`timescale 1ns/1ps
module esfm_top
#(
  parameter int unsigned FTS_DEBOUNCE_CYC = esfm_pkg::FTS_DEBOUNCE_CYC,
  parameter int unsigned SPEED_WIN_CYC    = esfm_pkg::SPEED_WIN_CYC
)
(
  input  wire logic        clk,                    // 10 MHz system clock
  input  wire logic        reset,                  // Sync reset, high
  input  wire logic        ign_on,                 // Ignition switch pin
  input  wire logic        engine_running,         // Engine running pin
  input  wire logic [12:0] fuel_temp_mv,           // Sensor voltage, mV
  input  wire logic [7:0]  fuel_temp_meas,         // Measured temp, C
  input  wire logic        pump_speed_sensor,      // Squared pump pickup
  input  wire logic        crank_position_sensor,  // Squared crank pickup
  output logic [7:0]       fuel_temp_out,          // Temp for correction
  output logic             fuel_temp_sensor_fault, // Thermistor fault
  output logic             pump_speed_sensor_fault,  // Pump pulses missing
  output logic             crank_position_sensor_fault, // Crank missing
  output logic [13:0]      engine_rpm,             // Engine speed, rpm
  output logic             pump_speed_pulse,       // Pump speed pulses
  output logic             timing_pulse,           // Injection tooth pulses
  output logic             speed_from_pump         // Speed taken from pump
);

  localparam int unsigned FW = esfm_pkg::FTS_CNT_W;
  localparam int unsigned SW = esfm_pkg::SPEED_WIN_W;
  localparam int unsigned RW = esfm_pkg::RPM_W;
  localparam logic [FW-1:0] FTS_LAST  = FW'(FTS_DEBOUNCE_CYC - 1);
  localparam logic [SW-1:0] WIN_LAST  = SW'(SPEED_WIN_CYC - 1);
  localparam logic [3:0]    PUMP_W    = 4'(esfm_pkg::PUMP_WEIGHT);
  localparam logic [3:0]    PUMP_W_M1 = 4'(esfm_pkg::PUMP_WEIGHT - 1);
  localparam logic [RW-1:0] RPM_K     = RW'(esfm_pkg::RPM_PER_SLOT);

  typedef struct packed
  {
    logic          ign_s1;
    logic          ign_s2;
    logic          run_s1;
    logic          run_s2;
    logic [FW-1:0] fts_cnt;
    logic          fts_fault;
    logic [7:0]    temp_out;
    logic [SW-1:0] win_cnt;
    logic [RW-1:0] slot_acc;
    logic [RW-1:0] rpm;
    logic [3:0]    derive_cnt;
    logic          pump_out;
    logic          timing_out;
    logic          pump_fault;
    logic          crank_fault;
  } esfm_top_t;

  esfm_top_t s;
  esfm_top_t next_s;

  logic pump_edge;
  logic crank_edge;
  logic fts_active;
  logic fts_bad;
  logic speed_ok;
  logic [RW-1:0] slot_inc;
  logic          fts_low;
  logic          fts_high;
  logic [2*RW-1:0] rpm_full;

  esfm_mon_if pump_mon ();
  esfm_mon_if crank_mon ();

  // A pin already high as reset ends gives one extra edge
  // Pickup shaping
  esfm_pulse_shaper u_pump_shaper
  (
    .clk   (clk),
    .reset (reset),
    .raw   (pump_speed_sensor),
    .pulse (pump_edge)
  );

  esfm_pulse_shaper u_crank_shaper
  (
    .clk   (clk),
    .reset (reset),
    .raw   (crank_position_sensor),
    .pulse (crank_edge)
  );

  // Shared speed gate of both monitors
  assign speed_ok = (s.rpm >= esfm_pkg::MIN_MON_RPM);

  assign pump_mon.enable       = speed_ok & ~crank_mon.fault;
  assign pump_mon.sensor_pulse = pump_edge;
  assign pump_mon.ref_pulse    = crank_edge;

  assign crank_mon.enable       = speed_ok & ~pump_mon.fault;
  assign crank_mon.sensor_pulse = crank_edge;
  assign crank_mon.ref_pulse    = pump_edge;

  // Each monitor measures its span in revolutions of the other sensor
  // Pump counted over ten crank revolutions
  esfm_pulse_monitor
  #(
    .MIN_PULSES (esfm_pkg::PUMP_MIN_PULSES),
    .REF_TEETH  (esfm_pkg::CRANK_SLOTS)
  )
  u_pump_mon
  (
    .clk   (clk),
    .reset (reset),
    .port  (pump_mon.mon)
  );

  esfm_pulse_monitor
  #(
    .MIN_PULSES (esfm_pkg::CRANK_MIN_PULSES),
    .REF_TEETH  (esfm_pkg::PUMP_TEETH)
  )
  u_crank_mon
  (
    .clk   (clk),
    .reset (reset),
    .port  (crank_mon.mon)
  );

  assign fts_active = s.ign_s2 | s.run_s2;
  // Range limits; exactly 0.1 V and 4.6 V still count as valid
  assign fts_low  = (fuel_temp_mv < esfm_pkg::FTS_LOW_MV);
  assign fts_high = (fuel_temp_mv > esfm_pkg::FTS_HIGH_MV);
  assign fts_bad  = fts_low | fts_high;

  // Full product so a high slot count saturates instead of wrapping
  assign rpm_full = s.slot_acc * RPM_K;

  // A pump tooth stands for several crank slots in the speed count
  always_comb
  begin
    slot_inc = '0;
    if (s.crank_fault)
    begin
      if (pump_edge)
      begin
        slot_inc = RW'(PUMP_W);
      end
    end
    else if (crank_edge)
    begin
      slot_inc = RW'(1);
    end
  end

  always_comb
  begin
    next_s        = s;
    next_s.ign_s1 = ign_on;
    next_s.ign_s2 = s.ign_s1;
    next_s.run_s1 = engine_running;
    next_s.run_s2 = s.run_s1;

    // After the fault latches the count freezes while the input stays bad; only reset clears the fault
    // Debounce restart
    if (!fts_active || !fts_bad)
    begin
      next_s.fts_cnt = '0;
    end
    else if (!s.fts_fault)
    begin
      if (s.fts_cnt == FTS_LAST)
      begin
        next_s.fts_fault = 1'b1;
      end
      else
      begin
        next_s.fts_cnt = s.fts_cnt + FW'(1);
      end
    end

    if (next_s.fts_fault)
    begin
      next_s.temp_out = esfm_pkg::FTS_SUBST_C;
    end
    else
    begin
      next_s.temp_out = fuel_temp_meas;
    end

    // Slots per window to rpm
    // A stalled crank still shows the old speed until this window ends,
    // which is what lets the crank check catch the stall at all
    if (s.win_cnt == WIN_LAST)
    begin
      next_s.win_cnt  = '0;
      next_s.slot_acc = slot_inc;
      if (|rpm_full[2*RW-1:RW])
      begin
        next_s.rpm = '1;
      end
      else
      begin
        next_s.rpm = rpm_full[RW-1:0];
      end
    end
    else
    begin
      next_s.win_cnt = s.win_cnt + SW'(1);
      // Saturate rather than wrap at very high speed
      if (s.slot_acc <= ~slot_inc)
      begin
        next_s.slot_acc = s.slot_acc + slot_inc;
      end
      else
      begin
        next_s.slot_acc = '1;
      end
    end

    // Derived pulses keep an arbitrary phase; only their rate matters
    // Pump speed from crank when pump faulted
    next_s.pump_out = 1'b0;
    if (s.pump_fault)
    begin
      if (crank_edge)
      begin
        if (s.derive_cnt == PUMP_W_M1)
        begin
          next_s.derive_cnt = '0;
          next_s.pump_out   = 1'b1;
        end
        else
        begin
          next_s.derive_cnt = s.derive_cnt + 4'h1;
        end
      end
    end
    else
    begin
      next_s.derive_cnt = '0;
      next_s.pump_out   = pump_edge;
    end

    // Timing from pump when crank faulted
    if (s.crank_fault)
    begin
      next_s.timing_out = pump_edge;
    end
    else
    begin
      next_s.timing_out = crank_edge;
    end

    // Flags trail the monitors by one cycle so every output is a register
    next_s.pump_fault  = pump_mon.fault;
    next_s.crank_fault = crank_mon.fault;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign fuel_temp_out               = s.temp_out;
  assign fuel_temp_sensor_fault      = s.fts_fault;
  assign pump_speed_sensor_fault     = s.pump_fault;
  assign crank_position_sensor_fault = s.crank_fault;
  assign engine_rpm                  = s.rpm;
  assign pump_speed_pulse            = s.pump_out;
  assign timing_pulse                = s.timing_out;
  assign speed_from_pump             = s.crank_fault;

endmodule : esfm_top

// [sim/esfm_sensor_model.sv]
// Behavioural crank and pump pickups, already squared.
// Assumes the bench sets run flags and half periods in clk cycles.
`timescale 1ns/1ps
module esfm_sensor_model
(
  input  wire logic       clk,        // System clock
  input  wire logic       crank_run,  // Crank wheel turning
  input  wire logic       pump_run,   // Pump shaft turning
  input  wire logic [7:0] crank_half, // Crank half period, cycles
  input  wire logic [7:0] pump_half,  // Pump half period, cycles
  output logic            crank,      // Squared crank waveform
  output logic            pump        // Squared pump waveform
);
  logic [7:0] crank_cnt = 8'h00;
  logic [7:0] pump_cnt  = 8'h00;
  initial crank = 1'b0;
  initial pump  = 1'b0;
  // A stalled wheel gives no flux change, so the squared line rests low
  always @(negedge clk)
  begin
    crank_cnt <= (!crank_run || crank_cnt == crank_half - 1) ? 8'h00
                 : crank_cnt + 8'h01;
    if (!crank_run)
      crank <= 1'b0;
    else if (crank_cnt == crank_half - 1)
      crank <= ~crank;
    pump_cnt <= (!pump_run || pump_cnt == pump_half - 1) ? 8'h00
                : pump_cnt + 8'h01;
    if (!pump_run)
      pump <= 1'b0;
    else if (pump_cnt == pump_half - 1)
      pump <= ~pump;
  end
endmodule : esfm_sensor_model

// [sim/esfm_top_asserts.sv]
// Port-level checker for esfm_top, attached by bind.
// Assumes a single clock and the synchronous active-high reset.
`timescale 1ns/1ps
module esfm_checker
(
  input wire logic        clk,                         // Clock
  input wire logic        reset,                       // Reset
  input wire logic        ign_on,                      // Ignition
  input wire logic        engine_running,              // Running
  input wire logic [12:0] fuel_temp_mv,                // Voltage
  input wire logic [7:0]  fuel_temp_meas,              // Measured
  input wire logic        pump_speed_sensor,           // Pump pin
  input wire logic        crank_position_sensor,       // Crank pin
  input wire logic [7:0]  fuel_temp_out,               // Temp out
  input wire logic        fuel_temp_sensor_fault,      // Temp fault
  input wire logic        pump_speed_sensor_fault,     // Pump fault
  input wire logic        crank_position_sensor_fault, // Crank fault
  input wire logic [13:0] engine_rpm,                  // Speed
  input wire logic        pump_speed_pulse,            // Pump pulse
  input wire logic        timing_pulse,                // Tooth pulse
  input wire logic        speed_from_pump              // Source
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  fuel_latch_a: assert property (
    fuel_temp_sensor_fault |=> fuel_temp_sensor_fault)
    else $error("fuel fault dropped");
  subst_temp_a: assert property (
    fuel_temp_sensor_fault |-> fuel_temp_out == esfm_pkg::FTS_SUBST_C)
    else $error("substitute temperature missing");
  temp_follow_a: assert property (
    !fuel_temp_sensor_fault && !$past(reset) && !$past(reset, 2)
    |-> fuel_temp_out == $past(fuel_temp_meas))
    else $error("temperature not passed on");
  in_range_a: assert property (
    !fuel_temp_sensor_fault && fuel_temp_mv >= esfm_pkg::FTS_LOW_MV
    && fuel_temp_mv <= esfm_pkg::FTS_HIGH_MV |=> !fuel_temp_sensor_fault)
    else $error("fault after in-range sample");
  check_off_a: assert property (
    (!ign_on && !engine_running) [*4] ##0 !fuel_temp_sensor_fault
    |=> !fuel_temp_sensor_fault)
    else $error("fuel fault while check inactive");
  pump_latch_a: assert property (
    pump_speed_sensor_fault |=> $stable(pump_speed_sensor_fault))
    else $error("pump fault dropped");
  one_fault_a: assert property (
    !(pump_speed_sensor_fault && crank_position_sensor_fault))
    else $error("both pulse faults set");
  speed_src_a: assert property (
    $rose(crank_position_sensor_fault) |-> ##[0:2] speed_from_pump)
    else $error("speed source not switched");
  tooth_one_a: assert property (
    timing_pulse |=> !timing_pulse)
    else $error("timing pulse too long");
  crank_edge_a: assert property (
    !crank_position_sensor_fault && $rose(crank_position_sensor)
    |-> ##[2:4] timing_pulse)
    else $error("crank edge lost");
  pump_edge_a: assert property (
    !pump_speed_sensor_fault && $rose(pump_speed_sensor)
    |-> ##[2:4] pump_speed_pulse)
    else $error("pump edge lost");
endmodule : esfm_checker

bind esfm_top esfm_checker esfm_checker_inst
(
  .clk                         (clk),
  .reset                       (reset),
  .ign_on                      (ign_on),
  .engine_running              (engine_running),
  .fuel_temp_mv                (fuel_temp_mv),
  .fuel_temp_meas              (fuel_temp_meas),
  .pump_speed_sensor           (pump_speed_sensor),
  .crank_position_sensor       (crank_position_sensor),
  .fuel_temp_out               (fuel_temp_out),
  .fuel_temp_sensor_fault      (fuel_temp_sensor_fault),
  .pump_speed_sensor_fault     (pump_speed_sensor_fault),
  .crank_position_sensor_fault (crank_position_sensor_fault),
  .engine_rpm                  (engine_rpm),
  .pump_speed_pulse            (pump_speed_pulse),
  .timing_pulse                (timing_pulse),
  .speed_from_pump             (speed_from_pump)
);

// [sim/tb.sv]
// Self-checking bench for esfm_top driven by the sensor model.
// Assumes shortened debounce and speed window parameters.
`timescale 1ns/1ps
module tb;
  localparam int DEB = 50;
  localparam int WIN = 2000;
  logic        clk, reset, ign_on, engine_running, crank_run, pump_run;
  logic        crank, pump, ft_flt, ps_flt, cp_flt, pspd, tpul, sfp;
  logic [12:0] fuel_temp_mv;
  logic [7:0]  fuel_temp_meas, fuel_temp_out;
  logic [13:0] engine_rpm;
  logic        mflt;
  int          n_errors, n_checks, cnt_t, cnt_p, mcnt;

  esfm_top #(.FTS_DEBOUNCE_CYC(DEB), .SPEED_WIN_CYC(WIN)) esfm_top_inst (
    .clk(clk), .reset(reset), .ign_on(ign_on),
    .engine_running(engine_running), .fuel_temp_mv(fuel_temp_mv),
    .fuel_temp_meas(fuel_temp_meas), .pump_speed_sensor(pump),
    .crank_position_sensor(crank), .fuel_temp_out(fuel_temp_out),
    .fuel_temp_sensor_fault(ft_flt), .pump_speed_sensor_fault(ps_flt),
    .crank_position_sensor_fault(cp_flt), .engine_rpm(engine_rpm),
    .pump_speed_pulse(pspd), .timing_pulse(tpul), .speed_from_pump(sfp));
  esfm_sensor_model esfm_sensor_model_inst (.clk(clk),
    .crank_run(crank_run), .pump_run(pump_run), .crank_half(8'h04),
    .pump_half(8'h03), .crank(crank), .pump(pump));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cnt_t += (tpul === 1'b1);
    cnt_p += (pspd === 1'b1);
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e)
      begin
        n_errors++;
        $display("Error %s expected %0h seen %0h", nm, e, g);
      end
  endtask : chk
  task automatic near(input string nm, input int e, input int g,
                      input int tol);
    n_checks++;
    if (g < e - tol || g > e + tol)
      begin
        n_errors++;
        $display("Error %s expected %0d seen %0d", nm, e, g);
      end
  endtask : near
  // Behavioural debounce model runs beside the stimulus
  task automatic fuel(input int n, input bit bad);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      if (!mflt && mcnt < DEB - 2)
        chk("fuel_temp_out", {8'h00, fuel_temp_meas}, fuel_temp_out);
      fuel_temp_mv = !bad ? 13'(100 + ($urandom % 3) * 2250)
        : ($urandom & 1) ? 13'(4601 + $urandom % 3591) : 13'($urandom % 100);
      fuel_temp_meas = 8'($urandom);
      mcnt = (bad && (ign_on || engine_running)) ? mcnt + 1 : 0;
      mflt |= (mcnt >= DEB);
    end
  endtask : fuel
  task automatic settle;
    fuel(3, 1'b0);
    chk("fuel fault", 16'(mflt), 16'(ft_flt));
    if (mflt)
      chk("substitute", 16'h0032, 16'(fuel_temp_out));
  endtask : settle
  task automatic pulses(input int et, input int ep);
    int t0;
    int p0;
    t0 = cnt_t;
    p0 = cnt_p;
    repeat (480) @(negedge clk);
    near("timing pulses", et, cnt_t - t0, 1);
    near("pump pulses", ep, cnt_p - p0, 1);
  endtask : pulses
  task automatic do_reset;
    reset = 1'b1;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    mflt = 1'b0;
    mcnt = 0;
  endtask : do_reset
  task automatic tally_and_finish;
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #(40000 * 100);
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(51));
    {ign_on, engine_running, crank_run, pump_run, mflt} = '0;
    fuel_temp_mv = 13'h07d0;
    fuel_temp_meas = 8'h14;
    mcnt = 0;
    do_reset();
    ign_on = 1'b1;
    crank_run = 1'b1;
    pump_run = 1'b1;
    repeat (4) @(negedge clk);
    fuel(30, 1'b0);
    settle();
    fuel(DEB - 1, 1'b1);
    fuel(1, 1'b0);
    fuel(DEB - 1, 1'b1);
    settle();
    ign_on = 1'b0;
    repeat (4) @(negedge clk);
    fuel(2 * DEB, 1'b1);
    settle();
    engine_running = 1'b1;
    repeat (4) @(negedge clk);
    fuel(DEB, 1'b1);
    settle();
    settle();
    repeat (2 * WIN) @(negedge clk);
    near("engine_rpm", WIN / 8 * 10, int'(engine_rpm), 10);
    pulses(60, 80);
    chk("faults", 16'h0000, 16'({ps_flt, cp_flt, sfp}));
    pump_run = 1'b0;
    for (int i = 0; i < 8000 && ps_flt !== 1'b1; i++) @(negedge clk);
    chk("pump fault", 16'h0001, 16'(ps_flt));
    repeat (2000) @(negedge clk);
    chk("crank fault", 16'h0000, 16'({cp_flt, sfp}));
    pulses(60, 10);
    pump_run = 1'b1;
    do_reset();
    chk("reset faults", 16'h0000, 16'({ft_flt, ps_flt, cp_flt}));
    repeat (3 * WIN + 40) @(negedge clk);
    chk("faults", 16'h0000, 16'({ps_flt, cp_flt}));
    crank_run = 1'b0;
    for (int i = 0; i < 1500 && cp_flt !== 1'b1; i++) @(negedge clk);
    chk("crank fault", 16'h0001, 16'(cp_flt));
    repeat (3) @(negedge clk);
    chk("takeover", 16'h0002, 16'({sfp, ps_flt}));
    pulses(80, 80);
    repeat (2 * WIN + 10) @(negedge clk);
    chk("engine_rpm", 16'h3fff, 16'(engine_rpm));
    tally_and_finish();
  end
endmodule : tb
